// ===== include/mail_pkg.sv
// Purpose: shared constants and types of the monitor alert interrupt logic
// Assumes: 8-bit register port, one 250 MHz clock
// Notes:   status and mask registers share an offset: reads hit status, writes hit mask
package mail_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] OFS_INT_HW_LIMIT_A  = 8'h13;
  localparam logic [7:0] OFS_EXT_HW_LIMIT_A  = 8'h14;
  localparam logic [7:0] OFS_CHANNEL_MODE    = 8'h16;
  localparam logic [7:0] OFS_INT_HW_LIMIT_B  = 8'h17;
  localparam logic [7:0] OFS_EXT_HW_LIMIT_B  = 8'h18;
  localparam logic [7:0] OFS_INT_TEMP_HIGH   = 8'h39;
  localparam logic [7:0] OFS_INT_TEMP_LOW    = 8'h3a;
  localparam logic [7:0] OFS_MAIN_CONFIG     = 8'h40;
  localparam logic [7:0] OFS_ALERT_FIRST     = 8'h43;
  localparam logic [7:0] OFS_ALERT_SECOND    = 8'h44;
  localparam logic [7:0] OFS_SECOND_CONFIG   = 8'h4a;
  localparam logic [7:0] OFS_COPY_FIRST      = 8'h4c;
  localparam logic [7:0] OFS_COPY_SECOND     = 8'h4d;

  // ==========================================================================
  // field positions
  localparam int BIT_MODE_IRQ_OFF   = 7;  // channel mode: 1 disables request group
  localparam int BIT_CFG1_INT_EN    = 1;
  localparam int BIT_CFG1_INT_CLR   = 3;
  localparam int BIT_CFG1_REINIT    = 7;
  localparam int BIT_CFG2_OVERHEAT_LINE_N_MSK = 0;
  localparam int BIT_CFG2_LOCK_A    = 1;
  localparam int BIT_CFG2_LOCK_EXT  = 2;
  localparam int BIT_CFG2_IRQ_EN    = 4;  // bits 6:4 enable requests 2:0
  localparam int NUM_IRQ            = 3;
  // status layout, first: 5:0 voltage/fan, 6 temp high, 7 temp low
  localparam int BIT_ST1_TEMP_HIGH  = 6;
  localparam int BIT_ST1_TEMP_LOW   = 7;
  // status layout, second: 3:0 voltage/fan, 5:4 remote temp, 6 line input, 7 hw
  localparam int BIT_ST2_REMOTE     = 4;
  localparam int BIT_ST2_LINE_IN    = 6;
  localparam int BIT_ST2_HW_TEMP    = 7;
  localparam logic [7:0] THERMAL_ST1 = 8'hc0;
  localparam logic [7:0] THERMAL_ST2 = 8'hf0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_MODE        = 8'h80;  // request group off
  localparam logic [7:0] RST_HW_LIMIT    = 8'h7f;
  localparam logic [7:0] RST_TEMP_HIGH   = 8'h7f;
  localparam logic [7:0] RST_TEMP_LOW    = 8'h80;

  // ==========================================================================
  // software pacing between status reads, kept for reference by the host side
  localparam int READ_SPACING_MS = 600;
  localparam int REFRESH_MIN_MS  = 300;

  // ==========================================================================
  // measurement results handed in at each conversion end
  typedef struct packed {
    logic [5:0] limit_err_first;
    logic [3:0] limit_err_second;
    logic [7:0] int_temp;         // signed two's complement
    logic [7:0] remote_diode_one;
    logic [7:0] remote_diode_two;
    logic [1:0] remote_err;
  } mail_meas_type;

  // all state of the block
  typedef struct packed {
    logic [7:0] hw_int_a;
    logic [7:0] hw_ext_a;
    logic [7:0] hw_int_b;
    logic [7:0] hw_ext_b;
    logic [7:0] mode;
    logic [7:0] temp_high;
    logic [7:0] temp_low;
    logic [7:0] cfg1;
    logic [7:0] cfg2;
    logic [7:0] mask1;
    logic [7:0] mask2;
    logic [7:0] st1;
    logic [7:0] st2;
    logic       lock_a;
    logic       lock_ext;
    logic [1:0] prev_out;       // temp above high / below low at last conversion
    logic [1:0] limit_new;      // limit rewritten since last conversion
    logic [1:0] temp_pend;      // temp crossing still allowed to interrupt
    logic       hw_err;
    logic [2:0] line_sync;
    logic       line_low;       // filtered level of the overheat line
    logic [7:0] rdata;
    logic       int_n;
  } mail_state_type;

endpackage

// ===== logic/mail_core.sv
// Purpose: alert interrupt logic of a hardware monitor
// Assumes: one clock, conversion end as one-cycle pulse, register port in the clock domain
// Notes:   the interrupt output is active low and registered
//
// Contract
// [R1] request group active when mode bit 7 is 0, each request needs its enable
// [R2] an enabled asserted request input asserts the interrupt output
// [R3] each conversion end updates voltage/fan limit checks, setting status when outside
// [R4] a set status bit with mask bit 0 asserts the interrupt
// [R5] reading voltage/fan status clears it; still outside next conversion sets it again
// [R6] status bits stay set after the quantity returns within limits
// [R7] internal temperature crossing high or low limit sets status and interrupts
// [R8] staying beyond the same limit re-sets status but raises no new interrupt
// [R9] temperature interrupts again on opposite crossing, reprogrammed limit, or other source
// [R10] internal temp checked against both internal hw limits; each diode against both external
// [R11] config 2 bit 1 locks first internal hw limit, bit 2 first external
// [R12] locks release only on re-initialise bit 7 of config 1 or power cycle
// [R13] hw limit error interrupts, survives status read, cleared by enables or clear bit
// [R14] external low on overheat line sets its status, interrupts, read clears it
// [R15] line still low after a read sets status again at next conversion end
// [R16] line low from our own overheat drive is not detected as input
// [R17] software waits 600 ms between status reads; an update needs 300 ms
// [R18] a clearing read releases the interrupt until the next status update
// [R19] copy registers return status content without clearing it
// [R20] masks map one-to-one, block only the interrupt, status still updates
// [R21] config 1 bit 1 enables output, bit 3 clears it and halts the loop
// [R22] thermal mask bit keeps thermal statuses updating but off the interrupt; here it also clears hw_err, so second status bit 7 is set for one cycle only
// [R23] requests have no status bits; they are masked only by their enables
// [R24] output low only when enabled, clear bit low and an unmasked source pends
`timescale 1ns/1ps
`default_nettype none

module mail_core (
  input  wire logic                   i_clk,
  input  wire logic                   i_arst_n,
  input  wire logic                   i_reg_wr,
  input  wire logic                   i_reg_rd,
  input  wire logic [7:0]             i_reg_addr,
  input  wire logic [7:0]             i_reg_wdata,
  output logic      [7:0]             o_reg_rdata,
  input  wire logic                   i_conv_done,
  input  wire mail_pkg::mail_meas_type i_meas,
  input  wire logic [2:0]             i_irq_req_n,
  input  wire logic                   i_overheat_line_n,
  input  wire logic                   i_overheat_drive,
  output logic                        o_loop_run,
  output logic                        o_int_n
);

  // ==========================================================================
  // state
  mail_pkg::mail_state_type state_reg;
  mail_pkg::mail_state_type state_next;

  logic        conv;
  logic        rd_st1;
  logic        rd_st2;
  logic [1:0]  temp_out;
  logic        hw_now;
  logic [2:0]  irq_act;
  logic [7:0]  gate1;
  logic [7:0]  gate2;
  logic        other_src;
  logic        temp_src;
  logic        line_edge;
  logic [1:0]  lim_wr;

  // ==========================================================================
  // comparisons on the current measurement
  always_comb begin
    // loop halts while the clear bit is high, so conversion ends are ignored
    conv = i_conv_done & ~state_reg.cfg1[mail_pkg::BIT_CFG1_INT_CLR];  // [R21]
    rd_st1 = i_reg_rd & (i_reg_addr == mail_pkg::OFS_ALERT_FIRST);
    rd_st2 = i_reg_rd & (i_reg_addr == mail_pkg::OFS_ALERT_SECOND);
    // a limit rewrite in the same cycle as a conversion end must not be lost
    lim_wr[0] = i_reg_wr & (i_reg_addr == mail_pkg::OFS_INT_TEMP_HIGH);  // [R9]
    lim_wr[1] = i_reg_wr & (i_reg_addr == mail_pkg::OFS_INT_TEMP_LOW);   // [R9]
    temp_out[0] = $signed(i_meas.int_temp) > $signed(state_reg.temp_high);  // [R7]
    temp_out[1] = $signed(i_meas.int_temp) < $signed(state_reg.temp_low);   // [R7]
    // every sensor against both of its hardware limits
    hw_now = ($signed(i_meas.int_temp) > $signed(state_reg.hw_int_a))          // [R10]
           | ($signed(i_meas.int_temp) > $signed(state_reg.hw_int_b))
           | ($signed(i_meas.remote_diode_one) > $signed(state_reg.hw_ext_a))
           | ($signed(i_meas.remote_diode_one) > $signed(state_reg.hw_ext_b))
           | ($signed(i_meas.remote_diode_two) > $signed(state_reg.hw_ext_a))
           | ($signed(i_meas.remote_diode_two) > $signed(state_reg.hw_ext_b));
  end

  // ==========================================================================
  // interrupt source gathering
  always_comb begin
    // requests have no status; only the group and per-input enables gate them
    for (int i = 0; i < mail_pkg::NUM_IRQ; i++) begin
      irq_act[i] = ~i_irq_req_n[i]                                          // [R2]
                 & ~state_reg.mode[mail_pkg::BIT_MODE_IRQ_OFF]             // [R1]
                 & state_reg.cfg2[mail_pkg::BIT_CFG2_IRQ_EN + i];          // [R23]
    end
    gate1 = state_reg.st1 & ~state_reg.mask1;  // [R4] [R20]
    gate2 = state_reg.st2 & ~state_reg.mask2;  // [R20]
    // temp bits of the first status only count while their crossing pends
    gate1[mail_pkg::BIT_ST1_TEMP_HIGH] = gate1[mail_pkg::BIT_ST1_TEMP_HIGH]
                                       & state_reg.temp_pend[0];           // [R8]
    gate1[mail_pkg::BIT_ST1_TEMP_LOW]  = gate1[mail_pkg::BIT_ST1_TEMP_LOW]
                                       & state_reg.temp_pend[1];           // [R8]
    // hardware error is taken from its own flag, not from status, so it bypasses the read clear
    gate2[mail_pkg::BIT_ST2_HW_TEMP] = state_reg.hw_err                    // [R13]
                                     & ~state_reg.mask2[mail_pkg::BIT_ST2_HW_TEMP];  // [R20]
    if (state_reg.cfg2[mail_pkg::BIT_CFG2_OVERHEAT_LINE_N_MSK]) begin
      gate1 = gate1 & ~mail_pkg::THERMAL_ST1;  // [R22]
      gate2 = gate2 & ~mail_pkg::THERMAL_ST2;  // [R22]
    end
    other_src = (|irq_act) | (|(gate1 & ~mail_pkg::THERMAL_ST1))
              | (|(gate2 & ~mail_pkg::THERMAL_ST2 & 8'h3f)) | (|(gate2 & 8'hc0))
              | (|(gate2 & 8'h30));
    temp_src  = |(gate1 & mail_pkg::THERMAL_ST1);
    line_edge = (state_reg.line_sync[1] == state_reg.line_sync[2])
              & ~state_reg.line_sync[2] & ~state_reg.line_low;
  end

  // ==========================================================================
  // next state
  always_comb begin
    state_next = state_reg;
    state_next.rdata = 8'h00;

    // three-stage synchroniser on the overheat line, change taken when stages agree
    state_next.line_sync = {state_reg.line_sync[1:0], i_overheat_line_n};
    if (state_reg.line_sync[1] == state_reg.line_sync[2]) begin
      state_next.line_low = ~state_reg.line_sync[2];
    end

    // ------------------------------------------------------------------ reads
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        mail_pkg::OFS_INT_HW_LIMIT_A: state_next.rdata = state_reg.hw_int_a;
        mail_pkg::OFS_EXT_HW_LIMIT_A: state_next.rdata = state_reg.hw_ext_a;
        mail_pkg::OFS_CHANNEL_MODE:   state_next.rdata = state_reg.mode;
        mail_pkg::OFS_INT_HW_LIMIT_B: state_next.rdata = state_reg.hw_int_b;
        mail_pkg::OFS_EXT_HW_LIMIT_B: state_next.rdata = state_reg.hw_ext_b;
        mail_pkg::OFS_INT_TEMP_HIGH:  state_next.rdata = state_reg.temp_high;
        mail_pkg::OFS_INT_TEMP_LOW:   state_next.rdata = state_reg.temp_low;
        mail_pkg::OFS_MAIN_CONFIG:    state_next.rdata = state_reg.cfg1;
        mail_pkg::OFS_SECOND_CONFIG:  state_next.rdata = state_reg.cfg2;
        mail_pkg::OFS_ALERT_FIRST:    state_next.rdata = state_reg.st1;
        mail_pkg::OFS_ALERT_SECOND:   state_next.rdata = state_reg.st2;
        mail_pkg::OFS_COPY_FIRST:     state_next.rdata = state_reg.st1;  // [R19]
        mail_pkg::OFS_COPY_SECOND:    state_next.rdata = state_reg.st2;  // [R19]
        default:                      state_next.rdata = 8'h00;
      endcase
    end

    // read clears first; any set below in the same cycle wins over the clear
    if (rd_st1) begin
      state_next.st1 = 8'h00;        // [R5] [R18]
      state_next.temp_pend = 2'b00;  // [R8]
    end
    if (rd_st2) begin
      state_next.st2 = 8'h00;        // [R5] [R14]
    end

    // ----------------------------------------------------------------- writes
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        mail_pkg::OFS_INT_HW_LIMIT_A: begin
          if (!state_reg.lock_a) begin
            state_next.hw_int_a = i_reg_wdata;  // [R11]
          end
        end
        mail_pkg::OFS_EXT_HW_LIMIT_A: begin
          if (!state_reg.lock_ext) begin
            state_next.hw_ext_a = i_reg_wdata;  // [R11]
          end
        end
        mail_pkg::OFS_CHANNEL_MODE:   state_next.mode = i_reg_wdata;
        mail_pkg::OFS_INT_HW_LIMIT_B: state_next.hw_int_b = i_reg_wdata;
        mail_pkg::OFS_EXT_HW_LIMIT_B: state_next.hw_ext_b = i_reg_wdata;
        mail_pkg::OFS_INT_TEMP_HIGH: begin
          state_next.temp_high = i_reg_wdata;
          state_next.limit_new[0] = 1'b1;  // [R9]
        end
        mail_pkg::OFS_INT_TEMP_LOW: begin
          state_next.temp_low = i_reg_wdata;
          state_next.limit_new[1] = 1'b1;  // [R9]
        end
        mail_pkg::OFS_MAIN_CONFIG: begin
          // re-initialise is a strobe: not stored, it only drops the locks
          state_next.cfg1 = i_reg_wdata & 8'h7f;
          if (i_reg_wdata[mail_pkg::BIT_CFG1_REINIT]) begin
            state_next.lock_a   = 1'b0;  // [R12]
            state_next.lock_ext = 1'b0;  // [R12]
          end
        end
        mail_pkg::OFS_SECOND_CONFIG: begin
          state_next.cfg2 = i_reg_wdata;
          // locks only ever set here; clearing the bit does not unlock
          if (i_reg_wdata[mail_pkg::BIT_CFG2_LOCK_A]) begin
            state_next.lock_a = 1'b1;    // [R11]
          end
          if (i_reg_wdata[mail_pkg::BIT_CFG2_LOCK_EXT]) begin
            state_next.lock_ext = 1'b1;  // [R11]
          end
        end
        mail_pkg::OFS_ALERT_FIRST:  state_next.mask1 = i_reg_wdata;  // [R20]
        mail_pkg::OFS_ALERT_SECOND: state_next.mask2 = i_reg_wdata;  // [R20]
        default: ;
      endcase
    end

    // ------------------------------------------------------ conversion update
    if (conv) begin
      // sticky: only sets, never clears on return within limits
      state_next.st1[5:0] = state_next.st1[5:0] | i_meas.limit_err_first;    // [R3] [R6]
      state_next.st2[3:0] = state_next.st2[3:0] | i_meas.limit_err_second;   // [R3] [R6]
      state_next.st2[5:4] = state_next.st2[5:4] | i_meas.remote_err;
      if (temp_out[0]) begin
        state_next.st1[mail_pkg::BIT_ST1_TEMP_HIGH] = 1'b1;  // [R7] [R8]
        if (!state_reg.prev_out[0] || state_reg.limit_new[0]) begin
          state_next.temp_pend[0] = 1'b1;                    // [R9]
        end
      end
      if (temp_out[1]) begin
        state_next.st1[mail_pkg::BIT_ST1_TEMP_LOW] = 1'b1;   // [R7] [R8]
        if (!state_reg.prev_out[1] || state_reg.limit_new[1]) begin
          state_next.temp_pend[1] = 1'b1;                    // [R9]
        end
      end
      state_next.prev_out  = temp_out;
      state_next.limit_new = lim_wr;  // [R9]
      if (hw_now) begin
        state_next.hw_err = 1'b1;  // [R13]
      end
      // line held low through a read is caught again at conversion end
      if (state_reg.line_low && !i_overheat_drive) begin
        state_next.st2[mail_pkg::BIT_ST2_LINE_IN] = 1'b1;    // [R15] [R16]
      end
    end
    // a fresh low on the line sets its status at once
    if (line_edge && !i_overheat_drive) begin
      state_next.st2[mail_pkg::BIT_ST2_LINE_IN] = 1'b1;      // [R14] [R16]
    end
    state_next.st2[mail_pkg::BIT_ST2_HW_TEMP] = state_next.hw_err;

    // hardware error leaves only through the thermal mask bit, a cleared output enable or the clear bit
    if (state_reg.cfg2[mail_pkg::BIT_CFG2_OVERHEAT_LINE_N_MSK]
        || state_reg.cfg1[mail_pkg::BIT_CFG1_INT_CLR]
        || !state_reg.cfg1[mail_pkg::BIT_CFG1_INT_EN]) begin
      state_next.hw_err = 1'b0;  // [R13]
    end

    // ------------------------------------------------------------ output pin
    // other sources assert the output on their own; they do not re-open a parked temperature crossing
    state_next.int_n = ~(state_reg.cfg1[mail_pkg::BIT_CFG1_INT_EN]     // [R24] [R21]
                       & ~state_reg.cfg1[mail_pkg::BIT_CFG1_INT_CLR]
                       & (other_src | temp_src));                     // [R9]
  end

  // ==========================================================================
  // state register; reset gives every field a constant
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg           <= '0;
      state_reg.hw_int_a  <= mail_pkg::RST_HW_LIMIT;
      state_reg.hw_ext_a  <= mail_pkg::RST_HW_LIMIT;
      state_reg.hw_int_b  <= mail_pkg::RST_HW_LIMIT;
      state_reg.hw_ext_b  <= mail_pkg::RST_HW_LIMIT;
      state_reg.mode      <= mail_pkg::RST_MODE;
      state_reg.temp_high <= mail_pkg::RST_TEMP_HIGH;
      state_reg.temp_low  <= mail_pkg::RST_TEMP_LOW;
      state_reg.cfg1      <= mail_pkg::RST_ZERO;
      state_reg.cfg2      <= mail_pkg::RST_ZERO;
      state_reg.line_sync <= 3'h7;
      state_reg.int_n     <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  assign o_reg_rdata = state_reg.rdata;
  assign o_int_n     = state_reg.int_n;
  assign o_loop_run  = ~state_reg.cfg1[mail_pkg::BIT_CFG1_INT_CLR];  // [R21]

endmodule

`default_nettype wire

// ===== verification/mail_host_model.sv
// Purpose: host side of the alert line, counts interrupt events
// Assumes: host samples the active-low line on the system clock
// Notes:   the host never drives the block; it only observes
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// host interrupt input
module mail_host_model (
  input  wire logic       i_clk,
  input  wire logic       i_arst_n,
  input  wire logic       i_int_n,
  output logic      [7:0] o_events
);
  logic int_d_reg;
  // a falling edge is one service request; a level that stays low is not counted twice
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_d_reg <= 1'b1;
      o_events  <= 8'h00;
    end else begin
      int_d_reg <= i_int_n;
      if (int_d_reg && !i_int_n) o_events <= o_events + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ===== verification/mail_core_assertions.sv
// Purpose: port-level checks of the alert interrupt logic
// Assumes: shadows track only the control bits and the first internal hw limit they need
// Notes:   status content is judged by the bench, apart from the read clear and copy read checks here
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// checker
module mail_core_assertions (
  input  wire logic                    i_clk,
  input  wire logic                    i_arst_n,
  input  wire logic                    i_reg_wr,
  input  wire logic                    i_reg_rd,
  input  wire logic [7:0]              i_reg_addr,
  input  wire logic [7:0]              i_reg_wdata,
  input  wire logic [7:0]              o_reg_rdata,
  input  wire logic                    i_conv_done,
  input  wire mail_pkg::mail_meas_type i_meas,
  input  wire logic [2:0]              i_irq_req_n,
  input  wire logic                    i_overheat_line_n,
  input  wire logic                    i_overheat_drive,
  input  wire logic                    o_loop_run,
  input  wire logic                    o_int_n
);
  logic       en_reg, clr_reg, off_reg, lk_reg;
  logic [2:0] ren_reg;
  logic [7:0] lim_reg;
  wire logic  rd43 = i_reg_rd && i_reg_addr == 8'h43;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  // shadow of the control bits; the lock only ever sets through a write
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {en_reg, clr_reg, off_reg, lk_reg} <= 4'h2;
      ren_reg <= 3'h0;
      lim_reg <= 8'h7f;
    end else if (i_reg_wr) begin
      if (i_reg_addr == 8'h40) {en_reg, clr_reg} <= {i_reg_wdata[1], i_reg_wdata[3]};
      if (i_reg_addr == 8'h40 && i_reg_wdata[7]) lk_reg <= 1'b0;
      if (i_reg_addr == 8'h16) off_reg <= i_reg_wdata[7];
      if (i_reg_addr == 8'h4a) ren_reg <= i_reg_wdata[6:4];
      if (i_reg_addr == 8'h4a && i_reg_wdata[1]) lk_reg <= 1'b1;
      if (i_reg_addr == 8'h13 && !lk_reg) lim_reg <= i_reg_wdata;
    end
  end
  read_clears_a: assert property ($past(rd43) && $past(rd43, 3) && !$past(i_conv_done)
    && !$past(i_conv_done, 2) && !$past(i_conv_done, 3) |-> o_reg_rdata == 8'h00)
    else $error("status not cleared by read");
  copy_keeps_a: assert property ($past(rd43) && $past(i_reg_rd && i_reg_addr == 8'h4c, 3)
    && !$past(i_conv_done) && !$past(i_conv_done, 2) && !$past(i_conv_done, 3)
    |-> o_reg_rdata == $past(o_reg_rdata, 2)) else $error("copy read changed status");
  loop_run_a: assert property (o_loop_run == !clr_reg)
    else $error("loop run flag wrong");
  int_enable_a: assert property (!o_int_n |-> $past(en_reg))
    else $error("interrupt while disabled");
  int_clear_a: assert property (clr_reg |=> o_int_n)
    else $error("interrupt while clear bit set");
  hw_lock_a: assert property ($past(i_reg_rd && i_reg_addr == 8'h13)
    |-> o_reg_rdata == $past(lim_reg)) else $error("hw limit lock broken");
  req_int_a: assert property ((en_reg && !clr_reg && !off_reg
    && (ren_reg & ~i_irq_req_n) != 3'h0) [*3] |-> !o_int_n) else $error("request lost");
  mode_read_a: assert property ($past(i_reg_rd && i_reg_addr == 8'h16)
    |-> o_reg_rdata[7] == $past(off_reg)) else $error("mode bit wrong");
  req_enable_a: assert property ($past(i_reg_rd && i_reg_addr == 8'h4a)
    |-> o_reg_rdata[6:4] == $past(ren_reg)) else $error("request enables wrong");
  cover property (!o_int_n ##1 o_int_n);
  cover property (i_conv_done && !o_int_n);
  cover property ($past(rd43) && $past(i_reg_rd && i_reg_addr == 8'h4c, 3));
endmodule
bind mail_core mail_core_assertions i_chk (.i_clk(i_clk), .i_arst_n(i_arst_n),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .i_conv_done(i_conv_done),
  .i_meas(i_meas), .i_irq_req_n(i_irq_req_n), .i_overheat_line_n(i_overheat_line_n),
  .i_overheat_drive(i_overheat_drive), .o_loop_run(o_loop_run), .o_int_n(o_int_n));
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench of the alert interrupt logic
// Assumes: register strobes are one-cycle pulses, one idle cycle between
// Notes:   read results are queued by the driver and checked by a monitor
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// bench
module tb;
  logic clk = 0, arst_n = 0, wr = 0, rd = 0, done = 0, line_n = 1, drv = 0, rd_d = 0;
  logic [7:0] addr = 0, wdata = 0, lf = 8'h0e, rdata, host_cnt;
  logic [2:0] req_n = 3'h7;
  logic       loop_run, int_n;
  logic [7:0] exp_q[$];
  int         num_errors = 0, n_tests = 0, cyc = 0;
  mail_pkg::mail_meas_type meas = '0;
  always #2 clk = ~clk;
  mail_core i_dut (.i_clk(clk), .i_arst_n(arst_n), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_conv_done(done),
    .i_meas(meas), .i_irq_req_n(req_n), .i_overheat_line_n(line_n),
    .i_overheat_drive(drv), .o_loop_run(loop_run), .o_int_n(int_n));
  mail_host_model i_host (.i_clk(clk), .i_arst_n(arst_n), .i_int_n(int_n), .o_events(host_cnt));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic stop_test;
    $display("mismatches=%0d comparisons=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cyc_w(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic conv(input mail_pkg::mail_meas_type m);
    @(posedge clk);
    {done, meas} <= {1'b1, m};
    @(posedge clk);
    done <= 1'b0;
  endtask
  // monitor: read data shows one cycle after the strobe is taken
  always @(posedge clk) begin
    rd_d <= rd;
    if (rd_d) chk8(rdata, exp_q.pop_front());
  end
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    mail_pkg::mail_meas_type m;
    logic [7:0] e;
    cyc_w(12);
    arst_n <= 1'b1;
    rd_reg(8'h16, 8'h80);
    rd_reg(8'h13, 8'h7f);
    rd_reg(8'h3a, 8'h80);
    rd_reg(8'h40, 8'h00);
    wr_reg(8'h40, 8'h02);
    lf = nxt(lf);
    e = {2'b00, lf[5:0] | 6'h01};
    m = '0;
    m.limit_err_first = e[5:0];
    conv(m);
    cyc_w(2);
    chk_bit(int_n, 1'b0);
    rd_reg(8'h4c, e);
    rd_reg(8'h43, e);
    rd_reg(8'h43, 8'h00);
    rd_reg(8'h4c, 8'h00);
    chk_bit(int_n, 1'b1);
    conv(m);
    conv('0);
    cyc_w(2);
    chk_bit(int_n, 1'b0);
    rd_reg(8'h43, e);
    wr_reg(8'h43, 8'hff);
    conv(m);
    cyc_w(2);
    chk_bit(int_n, 1'b1);
    rd_reg(8'h43, e);
    wr_reg(8'h43, 8'h00);
    conv(m);
    wr_reg(8'h40, 8'h0a);
    cyc_w(2);
    chk_bit(int_n, 1'b1);
    chk_bit(loop_run, 1'b0);
    m.limit_err_second = 4'h1;
    conv(m);
    wr_reg(8'h40, 8'h02);
    rd_reg(8'h44, 8'h00);
    rd_reg(8'h43, e);
    wr_reg(8'h4a, 8'h10);
    req_n <= 3'h6;
    cyc_w(3);
    chk_bit(int_n, 1'b1);
    wr_reg(8'h16, 8'h00);
    cyc_w(3);
    chk_bit(int_n, 1'b0);
    rd_reg(8'h44, 8'h00);
    rd_reg(8'h4a, 8'h10);
    req_n <= 3'h7;
    wr_reg(8'h4a, 8'h06);
    wr_reg(8'h13, 8'h50);
    wr_reg(8'h14, 8'h11);
    rd_reg(8'h13, 8'h7f);
    rd_reg(8'h14, 8'h7f);
    wr_reg(8'h40, 8'h82);
    wr_reg(8'h13, 8'h50);
    rd_reg(8'h13, 8'h50);
    wr_reg(8'h18, 8'h20);
    for (int k = 0; k < 2; k++) begin
      m = '0;
      if (k == 0) m.int_temp = 8'h51;
      else m.remote_diode_two = 8'h21;
      conv(m);
      rd_reg(8'h44, 8'h80);
      cyc_w(2);
      chk_bit(int_n, 1'b0);
      wr_reg(8'h40, 8'h0a);
      wr_reg(8'h40, 8'h02);
      cyc_w(2);
      chk_bit(int_n, 1'b1);
    end
    wr_reg(8'h39, 8'h30);
    m = '0;
    m.int_temp = 8'h40;
    conv(m);
    cyc_w(2);
    chk_bit(int_n, 1'b0);
    rd_reg(8'h43, 8'h40);
    conv(m);
    cyc_w(2);
    chk_bit(int_n, 1'b1);
    rd_reg(8'h4c, 8'h40);
    wr_reg(8'h39, 8'h38);
    conv(m);
    cyc_w(2);
    chk_bit(int_n, 1'b0);
    rd_reg(8'h43, 8'h40);
    {drv, line_n} <= 2'b10;
    cyc_w(8);
    rd_reg(8'h4d, 8'h00);
    drv <= 1'b0;
    conv('0);
    cyc_w(2);
    chk_bit(int_n, 1'b0);
    rd_reg(8'h44, 8'h40);
    cyc_w(2);
    chk_bit(int_n, 1'b1);
    conv('0);
    cyc_w(2);
    chk_bit(int_n, 1'b0);
    wr_reg(8'h4a, 8'h01);
    rd_reg(8'h44, 8'h40);
    conv('0);
    cyc_w(2);
    chk_bit(int_n, 1'b1);
    rd_reg(8'h4d, 8'h40);
    rd_reg(8'h44, 8'h40);
    // release, then a fresh low with our own drive off is caught without a conversion
    line_n <= 1'b1;
    cyc_w(6);
    line_n <= 1'b0;
    cyc_w(6);
    rd_reg(8'h4d, 8'h40);
    line_n <= 1'b1;
    cyc_w(3);
    chk_bit(host_cnt != 8'h00, 1'b1);
    stop_test();
  end
endmodule
`default_nettype wire
